// ### rtl/cmon_params.svh
// Constants of the current monitor: offsets, fields, resets and timing
`ifndef CMON_PARAMS_SVH
`define CMON_PARAMS_SVH

// =====================================================================
// Command codes
`define CMON_OFS_CFG      8'h00
`define CMON_OFS_SHUNT    8'h01
`define CMON_OFS_RAIL     8'h02
`define CMON_OFS_POWER    8'h03
`define CMON_OFS_CURRENT  8'h04
`define CMON_OFS_SCALE    8'h05
`define CMON_OFS_MASK     8'h06
`define CMON_OFS_LIMIT    8'h07
`define CMON_OFS_MAKER    8'hFE
`define CMON_OFS_SILICON  8'hFF

// =====================================================================
// Reset values
`define CMON_CFG_RESET    16'h4127
`define CMON_REG_RESET    16'h0000
// Identity codes, arbitrary values
`define CMON_MAKER_ID     16'hC0DE
`define CMON_SILICON_ID   16'h0A01
// Serial target address, low two bits from the straps, arbitrary base
`define CMON_ADDR_BASE    7'h40

// =====================================================================
// Configuration fields
`define CMON_SOFT_RST_BIT 15
`define CMON_AVG_MSB      11
`define CMON_AVG_LSB      9
`define CMON_RAIL_CT_MSB  8
`define CMON_RAIL_CT_LSB  6
`define CMON_SHUNT_CT_MSB 5
`define CMON_SHUNT_CT_LSB 3
`define CMON_MODE_MSB     2
`define CMON_MODE_LSB     0

// =====================================================================
// Conversion times in microseconds, and clock rate
`define CMON_CLK_MHZ      200
`define CMON_CT_US_0      139
`define CMON_CT_US_1      203
`define CMON_CT_US_2      269
`define CMON_CT_US_3      525
`define CMON_CT_US_4      1037
`define CMON_CT_US_5      2061
`define CMON_CT_US_6      4109
`define CMON_CT_US_7      8205

`endif

// ### rtl/cmon_pkg.sv
// Types shared by the current monitor modules
package cmon_pkg;

  typedef logic [15:0] cmon_word_t;

  typedef enum logic [2:0] {
    LS_IDLE,
    LS_ADDR,
    LS_ACK,
    LS_WRITE,
    LS_READ,
    LS_RACK
  } cmon_link_state_t;

  typedef enum logic [1:0] {
    CS_IDLE,
    CS_SHUNT,
    CS_RAIL,
    CS_AVG
  } cmon_conv_state_t;

endpackage

// ### rtl/cmon_conv_seq.sv
// Conversion sequencer: channel order, conversion timing, averaging
`timescale 1ns/10ps
`include "cmon_params.svh"
module cmon_conv_seq #(
  parameter int unsigned CT_CYC [8] = '{default: 1},
  parameter int unsigned TW         = 24
) (
  input  wire logic               ref_clk,
  input  wire logic               reset,
  input  wire logic               halt,
  input  wire logic               restart,
  input  wire logic [2:0]         mode,
  input  wire logic [2:0]         avg_sel,
  input  wire logic [2:0]         rail_ct_sel,
  input  wire logic [2:0]         shunt_ct_sel,
  input  wire cmon_pkg::cmon_word_t shunt_drop_voltage,
  input  wire cmon_pkg::cmon_word_t rail_voltage,
  output logic                    shunt_upd,
  output logic                    rail_upd,
  output cmon_pkg::cmon_word_t    shunt_avg,
  output cmon_pkg::cmon_word_t    rail_avg,
  output logic                    busy
);
  import cmon_pkg::*;

  // Samples per result as a power of two
  function automatic logic [3:0] avg_shift(input logic [2:0] sel);
    unique case (sel)
      3'h0: avg_shift = 4'h0;
      3'h1: avg_shift = 4'h2;
      3'h2: avg_shift = 4'h4;
      3'h3: avg_shift = 4'h6;
      3'h4: avg_shift = 4'h7;
      3'h5: avg_shift = 4'h8;
      3'h6: avg_shift = 4'h9;
      3'h7: avg_shift = 4'hA;
    endcase
  endfunction

  cmon_conv_state_t    state_reg;
  logic [TW-1:0]       timer_reg;
  logic [10:0]         samp_reg;
  logic signed [25:0]  shunt_sum_reg;
  logic [25:0]         rail_sum_reg;
  logic [10:0]         samp_last;
  logic [TW-1:0]       shunt_ct;
  logic [TW-1:0]       rail_ct;
  logic [TW-1:0]       first_ct;
  cmon_conv_state_t    first_state;
  logic                expire;

  assign samp_last   = (11'h001 << avg_shift(avg_sel)) - 11'h001;
  assign rail_ct     = TW'(CT_CYC[rail_ct_sel] - 1);
  assign shunt_ct    = TW'(CT_CYC[shunt_ct_sel] - 1);
  assign first_state = mode[0] ? CS_SHUNT : CS_RAIL;
  assign first_ct    = mode[0] ? shunt_ct : rail_ct;
  assign expire      = timer_reg == '0;
  assign busy        = state_reg != CS_IDLE;

  // =====================================================================
  // Sequence of one measurement pass
  always_ff @(posedge ref_clk) begin
    if (reset || halt) begin
      state_reg <= CS_IDLE;
      timer_reg <= '0;
      samp_reg  <= '0;
    end else begin
      unique case (state_reg)
        CS_IDLE: begin
          if (restart && (mode[0] || mode[1])) begin
            state_reg <= first_state;
            timer_reg <= first_ct;
            samp_reg  <= '0;
          end
        end
        CS_SHUNT, CS_RAIL: begin
          if (!expire) begin
            timer_reg <= timer_reg - 1'b1;
          end else if (state_reg == CS_SHUNT && mode[1]) begin
            state_reg <= CS_RAIL;
            timer_reg <= rail_ct;
          end else if (samp_reg == samp_last) begin
            state_reg <= CS_AVG;
          end else begin
            samp_reg  <= samp_reg + 1'b1;
            state_reg <= first_state;
            timer_reg <= first_ct;
          end
        end
        CS_AVG: begin
          if (mode[2]) begin
            state_reg <= first_state;
            timer_reg <= first_ct;
            samp_reg  <= '0;
          end else begin
            state_reg <= CS_IDLE;
          end
        end
      endcase
    end
  end

  // =====================================================================
  // Sample accumulation
  always_ff @(posedge ref_clk) begin
    if (reset || halt || state_reg == CS_IDLE || state_reg == CS_AVG) begin
      shunt_sum_reg <= '0;
      rail_sum_reg  <= '0;
    end else if (expire && state_reg == CS_SHUNT) begin
      shunt_sum_reg <= shunt_sum_reg +
                       {{10{shunt_drop_voltage[15]}}, shunt_drop_voltage};
    end else if (expire && state_reg == CS_RAIL) begin
      rail_sum_reg <= rail_sum_reg + {10'h000, rail_voltage};
    end
  end

  // =====================================================================
  // Averaged results
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      shunt_upd <= 1'b0;
      rail_upd  <= 1'b0;
      shunt_avg <= '0;
      rail_avg  <= '0;
    end else begin
      shunt_upd <= 1'b0;
      rail_upd  <= 1'b0;
      if (state_reg == CS_AVG) begin
        shunt_upd <= mode[0];
        rail_upd  <= mode[1];
        if (mode[0]) begin
          shunt_avg <= 16'(shunt_sum_reg >>> avg_shift(avg_sel));
        end
        if (mode[1]) begin
          rail_avg <= 16'(rail_sum_reg >> avg_shift(avg_sel));
        end
      end
    end
  end

  // =====================================================================
  // Checks
  sequence s_enter_rail;
    state_reg != CS_RAIL ##1 state_reg == CS_RAIL;
  endsequence

  a_halt_forces_idle: assert property (@(posedge ref_clk) disable iff (reset)
    halt |=> state_reg == CS_IDLE)
    else $error("conversion ran during halt");

  a_shutdown_no_conv: assert property (@(posedge ref_clk) disable iff (reset)
    (mode[1:0] == 2'b00) |-> state_reg == CS_IDLE)
    else $error("conversion in shutdown mode");

  a_channel_choice: assert property (@(posedge ref_clk) disable iff (reset)
    (state_reg == CS_SHUNT |-> mode[0]) and (state_reg == CS_RAIL |-> mode[1]))
    else $error("channel not selected by mode");

  a_triggered_single: assert property (@(posedge ref_clk) disable iff (reset)
    (state_reg == CS_AVG && !mode[2]) |=>
      (state_reg == CS_IDLE && shunt_upd == mode[0] && rail_upd == mode[1]))
    else $error("triggered pass did not end with results");

  a_cont_rerun: assert property (@(posedge ref_clk) disable iff (reset)
    (state_reg == CS_AVG && mode[2] && !halt) |=> state_reg != CS_IDLE)
    else $error("continuous mode stopped");

  a_rail_time: assert property (@(posedge ref_clk) disable iff (reset || halt)
    s_enter_rail |-> timer_reg == rail_ct)
    else $error("rail conversion time wrong");

endmodule

// ### rtl/cmon_regs.sv
// Current monitor register map, serial target and configuration control
// Behaviour
// - Every register is sixteen bits and moves as two bytes.
// - Reading the configuration never disturbs settings or conversion.
// - A configuration write halts conversion until the transfer ends.
// - After the write a fresh conversion starts with the new settings.
// - Writing one to bit 15 restores all defaults and the bit reads 0.
// - Bits 11:9 pick 1,4,16,64,128,256,512 or 1024 averaged samples.
// - Bits 8:6 pick the rail conversion time, default 1037 us.
// - Bits 5:3 pick the shunt conversion time, default 1037 us.
// - Mode codes 000 and 100 are shutdown with no conversions.
// - Codes 001, 010, 011 trigger shunt, rail, or both.
// - Codes 101, 110, 111 convert shunt, rail, or both continuously.
// - After reset the mode is continuous shunt and rail.
// - Configuration at 00h is read/write and resets to 4127h.
// - Rail result at 02h is read-only and resets to 0000h.
// - Shunt result at 01h is read-only and resets to 0000h.
`timescale 1ns/10ps
`include "cmon_params.svh"
module cmon_regs #(
  parameter int unsigned CT_CYC [8] = '{
    `CMON_CT_US_0 * `CMON_CLK_MHZ, `CMON_CT_US_1 * `CMON_CLK_MHZ,
    `CMON_CT_US_2 * `CMON_CLK_MHZ, `CMON_CT_US_3 * `CMON_CLK_MHZ,
    `CMON_CT_US_4 * `CMON_CLK_MHZ, `CMON_CT_US_5 * `CMON_CLK_MHZ,
    `CMON_CT_US_6 * `CMON_CLK_MHZ, `CMON_CT_US_7 * `CMON_CLK_MHZ}
) (
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  input  wire logic                 scl_in,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_oe,
  input  wire logic [1:0]           addr_strap,
  input  wire cmon_pkg::cmon_word_t shunt_drop_voltage,
  input  wire cmon_pkg::cmon_word_t rail_voltage,
  output logic                      conv_active
);
  import cmon_pkg::*;

  // =====================================================================
  // Decoding helpers
  function automatic logic is_writable(input logic [7:0] code);
    is_writable = (code == `CMON_OFS_CFG)  || (code == `CMON_OFS_SCALE) ||
                  (code == `CMON_OFS_MASK) || (code == `CMON_OFS_LIMIT);
  endfunction

  cmon_link_state_t link_reg;
  logic             scl_q_reg;
  logic             sda_q_reg;
  logic [7:0]       shift_reg;
  logic [3:0]       bit_reg;
  logic [1:0]       byte_idx_reg;
  logic             rd_mode_reg;
  logic             ack_drv_reg;
  logic             nack_reg;
  logic             rd_lo_reg;
  logic             sda_oe_reg;
  cmon_word_t       rd_word_reg;
  logic [7:0]       ptr_reg;
  logic [7:0]       hi_reg;
  cmon_word_t       cfg_reg;
  cmon_word_t       scale_reg;
  cmon_word_t       mask_reg;
  cmon_word_t       limit_reg;
  cmon_word_t       shunt_res_reg;
  cmon_word_t       rail_res_reg;
  cmon_word_t       cfg_pend_reg;
  logic             cfg_pend_vld_reg;
  logic             conv_halt_reg;
  logic             restart_reg;

  logic             scl_rise;
  logic             scl_fall;
  logic             start_det;
  logic             stop_det;
  logic             byte_done;
  logic [7:0]       new_byte;
  logic [7:0]       tx_byte;
  logic [6:0]       dev_addr;
  logic             wr_byte_stb;
  logic             end_xfer;
  logic             soft_rst;
  logic             shunt_upd;
  logic             rail_upd;
  cmon_word_t       shunt_avg;
  cmon_word_t       rail_avg;
  cmon_word_t       rd_mux;

  assign scl_rise  = scl_in && !scl_q_reg;
  assign scl_fall  = !scl_in && scl_q_reg;
  assign start_det = scl_in && scl_q_reg && sda_q_reg && !sda_in;
  assign stop_det  = scl_in && scl_q_reg && !sda_q_reg && sda_in;
  assign byte_done = scl_rise && bit_reg == 4'h7;
  assign new_byte  = {shift_reg[6:0], sda_in};
  assign tx_byte   = rd_lo_reg ? rd_word_reg[7:0] : rd_word_reg[15:8];
  assign dev_addr  = {5'(`CMON_ADDR_BASE >> 2), addr_strap};
  assign wr_byte_stb = link_reg == LS_WRITE && byte_done;
  assign end_xfer  = (stop_det || start_det) && conv_halt_reg;
  assign soft_rst  = end_xfer && cfg_pend_vld_reg &&
                     cfg_pend_reg[`CMON_SOFT_RST_BIT];
  assign sda_out   = 1'b0;
  assign sda_oe    = sda_oe_reg;

  // Register read decode; reads have no side effects
  always_comb begin
    unique case (ptr_reg)
      `CMON_OFS_CFG:     rd_mux = cfg_reg;
      `CMON_OFS_SHUNT:   rd_mux = shunt_res_reg;
      `CMON_OFS_RAIL:    rd_mux = rail_res_reg;
      `CMON_OFS_SCALE:   rd_mux = scale_reg;
      `CMON_OFS_MASK:    rd_mux = mask_reg;
      `CMON_OFS_LIMIT:   rd_mux = limit_reg;
      `CMON_OFS_MAKER:   rd_mux = `CMON_MAKER_ID;
      `CMON_OFS_SILICON: rd_mux = `CMON_SILICON_ID;
      default:           rd_mux = `CMON_REG_RESET;
    endcase
  end

  // =====================================================================
  // Line sampling
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      scl_q_reg <= scl_in;
      sda_q_reg <= sda_in;
    end
  end

  // =====================================================================
  // Serial target state machine
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      link_reg     <= LS_IDLE;
      shift_reg    <= '0;
      bit_reg      <= '0;
      byte_idx_reg <= '0;
      rd_mode_reg  <= 1'b0;
      ack_drv_reg  <= 1'b0;
      nack_reg     <= 1'b0;
      rd_lo_reg    <= 1'b0;
      sda_oe_reg   <= 1'b0;
      rd_word_reg  <= '0;
    end else if (start_det) begin
      link_reg     <= LS_ADDR;
      bit_reg      <= '0;
      byte_idx_reg <= '0;
      sda_oe_reg   <= 1'b0;
    end else if (stop_det) begin
      link_reg   <= LS_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      unique case (link_reg)
        LS_IDLE: ;
        LS_ADDR: begin
          if (scl_rise) begin
            shift_reg <= new_byte;
            bit_reg   <= bit_reg + 1'b1;
          end
          if (byte_done) begin
            if (new_byte[7:1] == dev_addr) begin
              link_reg    <= LS_ACK;
              rd_mode_reg <= new_byte[0];
              ack_drv_reg <= 1'b0;
              rd_word_reg <= rd_mux;
              rd_lo_reg   <= 1'b0;
            end else begin
              link_reg <= LS_IDLE;
            end
          end
        end
        LS_ACK: begin
          if (scl_fall && !ack_drv_reg) begin
            ack_drv_reg <= 1'b1;
            sda_oe_reg  <= 1'b1;
          end else if (scl_fall) begin
            ack_drv_reg <= 1'b0;
            if (rd_mode_reg) begin
              link_reg   <= LS_READ;
              sda_oe_reg <= !tx_byte[7];
              bit_reg    <= 4'h1;
            end else begin
              link_reg   <= LS_WRITE;
              sda_oe_reg <= 1'b0;
              bit_reg    <= '0;
            end
          end
        end
        LS_WRITE: begin
          if (scl_rise) begin
            shift_reg <= new_byte;
            bit_reg   <= bit_reg + 1'b1;
          end
          if (byte_done) begin
            link_reg     <= LS_ACK;
            ack_drv_reg  <= 1'b0;
            byte_idx_reg <= (byte_idx_reg == 2'h2) ? 2'h1 :
                            byte_idx_reg + 1'b1;
          end
        end
        LS_READ: begin
          if (scl_fall && bit_reg == 4'h8) begin
            sda_oe_reg <= 1'b0;
            link_reg   <= LS_RACK;
          end else if (scl_fall) begin
            sda_oe_reg <= !tx_byte[3'(4'h7 - bit_reg)];
            bit_reg    <= bit_reg + 1'b1;
          end
        end
        LS_RACK: begin
          if (scl_rise) begin
            nack_reg <= sda_in;
          end
          if (scl_fall && nack_reg) begin
            link_reg <= LS_IDLE;
          end else if (scl_fall) begin
            rd_lo_reg  <= !rd_lo_reg;
            link_reg   <= LS_READ;
            sda_oe_reg <= rd_lo_reg ? !rd_word_reg[15] : !rd_word_reg[7];
            bit_reg    <= 4'h1;
          end
        end
      endcase
    end
  end

  // =====================================================================
  // Pointer, halt and restart of conversion
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ptr_reg       <= '0;
      hi_reg        <= '0;
      conv_halt_reg <= 1'b0;
      restart_reg   <= 1'b1;
    end else begin
      restart_reg <= end_xfer;
      if (wr_byte_stb && byte_idx_reg == 2'h0) begin
        ptr_reg <= new_byte;
      end
      if (wr_byte_stb && byte_idx_reg == 2'h1) begin
        hi_reg <= new_byte;
      end
      if (end_xfer) begin
        conv_halt_reg <= 1'b0;
      // Halt on the fall after a data bit; a restart after the pointer
      // byte alone is a read and must not halt
      end else if (link_reg == LS_WRITE && scl_fall && bit_reg != 4'h0 &&
                   byte_idx_reg != 2'h0 && ptr_reg == `CMON_OFS_CFG) begin
        conv_halt_reg <= 1'b1;
      end
    end
  end

  // =====================================================================
  // Register writes
  always_ff @(posedge ref_clk) begin
    if (reset || soft_rst) begin
      cfg_reg          <= `CMON_CFG_RESET;
      scale_reg        <= `CMON_REG_RESET;
      mask_reg         <= `CMON_REG_RESET;
      limit_reg        <= `CMON_REG_RESET;
      cfg_pend_reg     <= `CMON_REG_RESET;
      cfg_pend_vld_reg <= 1'b0;
    end else begin
      if (end_xfer) begin
        cfg_pend_vld_reg <= 1'b0;
        if (cfg_pend_vld_reg) begin
          cfg_reg <= cfg_pend_reg;
        end
      end
      if (wr_byte_stb && byte_idx_reg == 2'h2 && is_writable(ptr_reg)) begin
        unique case (ptr_reg)
          `CMON_OFS_CFG: begin
            cfg_pend_reg     <= {hi_reg, new_byte};
            cfg_pend_vld_reg <= 1'b1;
          end
          `CMON_OFS_SCALE: scale_reg <= {hi_reg, new_byte};
          `CMON_OFS_MASK:  mask_reg  <= {hi_reg, new_byte};
          default:         limit_reg <= {hi_reg, new_byte};
        endcase
      end
    end
  end

  // =====================================================================
  // Measurement results
  always_ff @(posedge ref_clk) begin
    if (reset || soft_rst) begin
      shunt_res_reg <= `CMON_REG_RESET;
      rail_res_reg  <= `CMON_REG_RESET;
    end else begin
      if (shunt_upd) begin
        shunt_res_reg <= shunt_avg;
      end
      if (rail_upd) begin
        rail_res_reg <= rail_avg;
      end
    end
  end

  cmon_conv_seq #(
    .CT_CYC (CT_CYC),
    .TW     (24)
  ) u_seq (
    .ref_clk            (ref_clk),
    .reset              (reset),
    .halt               (conv_halt_reg),
    .restart            (restart_reg),
    .mode               (cfg_reg[`CMON_MODE_MSB:`CMON_MODE_LSB]),
    .avg_sel            (cfg_reg[`CMON_AVG_MSB:`CMON_AVG_LSB]),
    .rail_ct_sel        (cfg_reg[`CMON_RAIL_CT_MSB:`CMON_RAIL_CT_LSB]),
    .shunt_ct_sel       (cfg_reg[`CMON_SHUNT_CT_MSB:`CMON_SHUNT_CT_LSB]),
    .shunt_drop_voltage (shunt_drop_voltage),
    .rail_voltage       (rail_voltage),
    .shunt_upd          (shunt_upd),
    .rail_upd           (rail_upd),
    .shunt_avg          (shunt_avg),
    .rail_avg           (rail_avg),
    .busy               (conv_active)
  );

  // =====================================================================
  // Checks
  sequence s_cfg_data_bit;
    link_reg == LS_WRITE && scl_fall && bit_reg != 4'h0 &&
      byte_idx_reg != 2'h0 && ptr_reg == `CMON_OFS_CFG;
  endsequence

  a_reset_config: assert property (@(posedge ref_clk)
    reset |=> cfg_reg == `CMON_CFG_RESET)
    else $error("configuration reset value wrong");

  a_reset_mode: assert property (@(posedge ref_clk)
    reset ##1 !reset |-> cfg_reg[`CMON_MODE_MSB:`CMON_MODE_LSB] == 3'h7
      ##1 conv_active)
    else $error("reset mode is not continuous");

  a_reset_results: assert property (@(posedge ref_clk)
    reset |=> (shunt_res_reg == 16'h0000 && rail_res_reg == 16'h0000))
    else $error("result reset value wrong");

  a_soft_reset: assert property (@(posedge ref_clk) disable iff (reset)
    soft_rst |=> (cfg_reg == `CMON_CFG_RESET && scale_reg == 16'h0000 &&
                  !cfg_reg[`CMON_SOFT_RST_BIT]))
    else $error("soft reset did not restore defaults");

  a_read_no_effect: assert property (@(posedge ref_clk) disable iff (reset)
    (link_reg == LS_READ && !start_det && !stop_det) |=>
      ($stable(cfg_reg) && !conv_halt_reg))
    else $error("read disturbed configuration");

  a_cfg_halt: assert property (@(posedge ref_clk) disable iff (reset)
    s_cfg_data_bit |=> conv_halt_reg)
    else $error("configuration write did not halt conversion");

  a_restart_after: assert property (@(posedge ref_clk) disable iff (reset)
    end_xfer |=> (restart_reg && !conv_halt_reg) ##1 !restart_reg)
    else $error("no restart after configuration write");

  a_ro_ignored: assert property (@(posedge ref_clk) disable iff (reset)
    (wr_byte_stb && byte_idx_reg == 2'h2 && !is_writable(ptr_reg)) |=>
      ($stable(scale_reg) && $stable(mask_reg) && $stable(limit_reg) &&
       !cfg_pend_vld_reg))
    else $error("write to read-only code took effect");

endmodule

// ### test/cmon_host.sv
// Serial host model driving the monitor's open-drain link
`timescale 1ns/10ps
module cmon_host #(
  parameter logic [6:0] ADDR = 7'h41
) (
  input  wire logic ref_clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic half();
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  task automatic start();
    sda_drv = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_drv = 1'b0;
    half();
    scl = 1'b0;
    half();
  endtask
  task automatic stop();
    sda_drv = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_drv = 1'b1;
    half();
  endtask
  // Eight data bits then the acknowledge bit, 1 releases the line
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_drv = tx[i];
      half();
      scl = 1'b1;
      half();
      rx[i] = sda_line;
      scl = 1'b0;
      half();
    end
  endtask
  int ack_miss = 0;
  // Byte that the target must acknowledge
  task automatic xa(input logic [8:0] tx);
    logic [8:0] r;
    xfer(tx, r);
    if (r[0] !== 1'b0) ack_miss++;
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [15:0] d);
    start();
    xa({ADDR, 2'b01});
    xa({ptr, 1'b1});
    xa({d[15:8], 1'b1});
    xa({d[7:0], 1'b1});
    stop();
  endtask
  task automatic rd(input logic [7:0] ptr, output logic [15:0] d);
    logic [8:0] r;
    start();
    xa({ADDR, 2'b01});
    xa({ptr, 1'b1});
    start();
    xa({ADDR, 2'b11});
    xfer(9'h1FE, r);
    d[15:8] = r[8:1];
    xfer(9'h1FF, r);
    d[7:0] = r[8:1];
    stop();
  endtask
endmodule

// ### test/testbench.sv
// Self-checking bench for the monitor register block
`timescale 1ns/10ps
`include "cmon_params.svh"
module testbench;
  import cmon_pkg::*;
  typedef struct { logic [7:0] p; cmon_word_t e; } cmon_row_t;
  logic       ref_clk;
  logic       reset;
  logic       scl;
  logic       sda_drv;
  logic       sda_out;
  logic       sda_oe;
  logic       conv_active;
  wire        sda_line = sda_drv & (sda_out | ~sda_oe);
  cmon_word_t shunt_v;
  cmon_word_t rail_v;
  cmon_word_t got;
  int         num_errors = 0;
  int         checked = 0;
  cmon_row_t  rows [10] = '{'{8'h00, 16'h4127}, '{8'h01, 16'h0}, '{8'h02, 16'h0},
    '{8'h03, 16'h0}, '{8'h04, 16'h0}, '{8'h05, 16'h0}, '{8'h06, 16'h0},
    '{8'h07, 16'h0}, '{8'hFE, `CMON_MAKER_ID}, '{8'hFF, `CMON_SILICON_ID}};
  cmon_regs #(.CT_CYC('{20, 21, 22, 23, 24, 25, 26, 27})) DUT (
    .ref_clk(ref_clk), .reset(reset), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap(2'b01),
    .shunt_drop_voltage(shunt_v), .rail_voltage(rail_v),
    .conv_active(conv_active));
  cmon_host #(.ADDR(7'h41)) host (.ref_clk(ref_clk), .sda_line(sda_line),
    .scl(scl), .sda_drv(sda_drv));
  // =====================================================================
  // Compare and closing tasks
  task automatic chk(input string w, input cmon_word_t e, input cmon_word_t a);
    checked++;
    if (a !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, a);
    end
  endtask
  task automatic rd_chk(input logic [7:0] p, input cmon_word_t e);
    host.rd(p, got);
    chk($sformatf("reg %h", p), e, got);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // =====================================================================
  // Clock, watchdog and tests
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    summarize();
  end
  initial begin
    reset = 1'b1;
    shunt_v = 16'h0000;
    rail_v = 16'h0000;
    repeat (3) @(posedge ref_clk);
    #1 reset = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk("conv_active", 16'h0001, {15'h0, conv_active});
    foreach (rows[i]) rd_chk(rows[i].p, rows[i].e);
    $display("test reset values done");
    host.wr(8'h05, 16'h1234);
    rd_chk(8'h05, 16'h1234);
    host.wr(8'h01, 16'h5555);
    host.wr(8'h10, 16'hAAAA);
    rd_chk(8'h01, 16'h0000);
    rd_chk(8'h00, 16'h4127);
    $display("test access kinds done");
    shunt_v = 16'h8300;
    rail_v = 16'h0200;
    host.wr(8'h00, 16'h0207);
    repeat (400) @(posedge ref_clk);
    rd_chk(8'h01, 16'h8300);
    rd_chk(8'h02, 16'h0200);
    for (int m = 0; m < 8; m++) begin
      host.wr(8'h00, {13'h0, 3'(m)});
      chk("conv_active", {15'h0, m[1:0] != 2'b00}, {15'h0, conv_active});
    end
    $display("test modes done");
    shunt_v = 16'h0011;
    rail_v = 16'h0022;
    host.wr(8'h00, 16'h0203);
    // Inputs change after two shunt and one rail sample of four
    repeat (60) @(posedge ref_clk);
    #1 shunt_v = 16'h0099;
    rail_v = 16'h0088;
    for (int n = 0; n < 500 && conv_active !== 1'b0; n++) @(posedge ref_clk) #1;
    shunt_v = 16'h0300;
    rail_v = 16'h0400;
    repeat (200) @(posedge ref_clk);
    #1 chk("conv_active", 16'h0000, {15'h0, conv_active});
    rd_chk(8'h00, 16'h0203);
    rd_chk(8'h01, 16'h0055);
    rd_chk(8'h02, 16'h006E);
    $display("test triggered done");
    host.wr(8'h00, 16'h8000);
    rd_chk(8'h00, 16'h4127);
    rd_chk(8'h05, 16'h0000);
    $display("test soft reset done");
    host.wr(8'h00, 16'h0003);
    reset = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 reset = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk("conv_active", 16'h0001, {15'h0, conv_active});
    rd_chk(8'h00, 16'h4127);
    $display("test mid-run reset done");
    chk("ack_miss", 16'h0000, 16'(host.ack_miss));
    summarize();
  end
endmodule
